// *** hw/rcs_reset_sequencer.v ***
// Purpose: merge reset sources, record cause, time master reset and clock release
// Assumes: sources synchronous to pclk; presetn is the power-on reset
// Notes: registers over APB; one clock enable freezes all state
`include "rcs_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_sequencer #(
	parameter TPOR_CYC = `RCS_CYC(`RCS_TPOR_US),
	parameter TPWRT_CYC = `RCS_CYC(`RCS_TPWRT_US),
	parameter TRST_CYC = `RCS_CYC(`RCS_TRST_US),
	parameter TFSCM_CYC = `RCS_CYC(`RCS_TFSCM_US),
	parameter TRC_CYC = `RCS_CYC(`RCS_TRC_US),
	parameter TLOCK_CYC = `RCS_CYC(`RCS_TLOCK_US),
	parameter OST_PERIODS = `RCS_OST_PERIODS
) (
	// APB
	input wire pclk,
	input wire presetn,
	input wire pclken,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Reset sources and power-save events, one-cycle or level
	input wire brownout_reset,
	input wire master_clear_pin,
	input wire reset_instr,
	input wire watchdog_timeout,
	input wire config_mismatch,
	input wire trap_conflict,
	input wire illegal_access,
	input wire pwrsave_sleep,
	input wire pwrsave_idle,
	// Configuration and oscillator
	input wire clock_switch_en,
	input wire two_speed_en,
	input wire watchdog_config_enable,
	input wire regulator_enable_pin,
	input wire [2:0] new_osc_config,
	input wire [2:0] current_osc_select,
	input wire osc_tick,
	input wire pll_locked,
	// Outputs
	output reg master_reset,
	output reg sys_clock_release,
	output reg [2:0] clock_source,
	output reg clock_fail_monitor_en,
	output reg watchdog_enable,
	output reg progmem_sleep_power,
	output reg regulator_standby
);
	localparam ST_HOLD = 4'h1;
	localparam ST_WAIT = 4'h2;
	localparam ST_RUN = 4'h4;
	localparam ST_MON = 4'h8;
	localparam [1:0] K_POR = 2'h0;
	localparam [1:0] K_BOR = 2'h1;
	localparam [1:0] K_OTHER = 2'h2;
	localparam [1:0] R_STATUS = 2'h0;
	localparam [1:0] R_CLKSEL = 2'h1;
	localparam [1:0] R_SEQ = 2'h2;
	localparam [1:0] R_NONE = 2'h3;

	// Delay sums kept 32 bits wide, cut to the counter widths on use
	localparam [31:0] DLY_POR = TPOR_CYC + TPWRT_CYC + TRST_CYC;
	localparam [31:0] DLY_BOR = TPWRT_CYC + TRST_CYC;
	localparam [31:0] DLY_OTHER = TRST_CYC;
	localparam [31:0] DLY_RC = TRC_CYC;
	localparam [31:0] DLY_RCPLL = TRC_CYC + TLOCK_CYC;
	localparam [31:0] DLY_OST = OST_PERIODS;
	localparam [31:0] DLY_CLOCK_FAIL_MONITOR = TFSCM_CYC;

	reg [15:0] status_q, status_d;
	reg [3:0] state_q;
	reg [1:0] kind_q;
	reg [23:0] rst_cnt_q;
	reg [23:0] clk_cnt_q;
	reg [10:0] ost_cnt_q;
	reg [15:0] clock_fail_monitor_cnt_q;
	reg clk_ready_q;
	reg [2:0] osc_sel_q;

	wire wr = psel & penable & pwrite & pclken;
	wire any_src = brownout_reset | master_clear_pin | reset_instr | watchdog_timeout
		| config_mismatch | trap_conflict | illegal_access;
	wire [15:0] wmask = `RCS_STATUS_MASK;

	function is_xtal;
		input [2:0] s;
		begin
			is_xtal = (s == `RCS_OSC_XT) | (s == `RCS_OSC_XTPLL) | (s == `RCS_OSC_SOSC);
		end
	endfunction
	function is_pll;
		input [2:0] s;
		begin
			is_pll = (s == `RCS_OSC_XTPLL) | (s == `RCS_OSC_FRCPLL);
		end
	endfunction

	// Register decode shared by the write and read paths
	function [1:0] reg_sel;
		input [11:0] a;
		begin
			case (a)
				`RCS_ADDR_STATUS: reg_sel = R_STATUS;
				`RCS_ADDR_CLKSEL: reg_sel = R_CLKSEL;
				`RCS_ADDR_SEQ: reg_sel = R_SEQ;
				default: reg_sel = R_NONE;
			endcase
		end
	endfunction

	// Reset delay per kind
	function [23:0] rst_delay;
		input [1:0] k;
		begin
			case (k)
				K_POR: rst_delay = DLY_POR[23:0];
				K_BOR: rst_delay = DLY_BOR[23:0];
				default: rst_delay = DLY_OTHER[23:0];
			endcase
		end
	endfunction

	// Clock delay per source; oscillator count handled separately
	function [23:0] clk_delay;
		input [2:0] s;
		begin
			case (s)
				`RCS_OSC_EC: clk_delay = 24'h000000;
				`RCS_OSC_FRCPLL: clk_delay = DLY_RCPLL[23:0];
				`RCS_OSC_XT, `RCS_OSC_XTPLL, `RCS_OSC_SOSC: clk_delay = 24'h000000;
				default: clk_delay = DLY_RC[23:0];
			endcase
		end
	endfunction

	// Effective source: switching and two-speed start-up
	wire [2:0] base_sel = (clock_switch_en && kind_q == K_OTHER) ? current_osc_select
		: new_osc_config;
	wire [2:0] eff_sel = two_speed_en ? `RCS_OSC_FRC : base_sel;

	// Status register next value; events win over software clears
	always @* begin
		status_d = status_q;
		if (wr && reg_sel(paddr) == R_STATUS)
			status_d = pwdata[15:0] & wmask;
		if (pwrsave_sleep | pwrsave_idle)
			status_d[`RCS_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
		if (trap_conflict) status_d[`RCS_B_TRAP] = 1'b1;
		if (config_mismatch) status_d[`RCS_B_CFGM] = 1'b1;
		if (illegal_access) status_d[`RCS_B_ILL] = 1'b1;
		if (master_clear_pin) status_d[`RCS_B_PIN] = 1'b1;
		if (reset_instr) status_d[`RCS_B_SWR] = 1'b1;
		if (watchdog_timeout) status_d[`RCS_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
		if (pwrsave_sleep) status_d[`RCS_B_SLEEP] = 1'b1;
		if (pwrsave_idle) status_d[`RCS_B_IDLE] = 1'b1;
		if (brownout_reset) status_d[`RCS_B_BOR] = 1'b1;
	end

	// Status flags; power-on reset is presetn and acts without the clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= `RCS_STATUS_POR;
		end else if (pclken) begin
			status_q <= status_d;
		end
	end

	// Register bus: read data is taken at the setup edge, so no wait states
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (pclken) begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				case (reg_sel(paddr))
					R_STATUS: prdata <= {16'h0000, status_q};
					R_CLKSEL: prdata <= {28'h0000000, clk_ready_q, osc_sel_q};
					R_SEQ: prdata <= {28'h0000000, state_q};
					default: begin
						prdata <= 32'h00000000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// Power and watchdog controls follow the flags of the same edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_enable <= 1'b1;
			progmem_sleep_power <= 1'b0;
			regulator_standby <= 1'b1;
		end else if (pclken) begin
			watchdog_enable <= watchdog_config_enable | status_d[`RCS_B_SWDT];
			progmem_sleep_power <= status_d[`RCS_B_PROGMEM_SLEEP_POWER];
			regulator_standby <= ~status_d[`RCS_B_PROGMEM_SLEEP_POWER];
		end
	end

	// Clock waits; only power-on and brown-out restart the oscillator
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_cnt_q <= 24'h000000;
			ost_cnt_q <= 11'h000;
			clk_ready_q <= 1'b0;
		end else if (pclken && !any_src) begin
			case (state_q)
				ST_HOLD: begin
					clk_cnt_q <= (kind_q == K_OTHER) ? 24'h000000 : clk_delay(eff_sel);
					ost_cnt_q <= (kind_q != K_OTHER && is_xtal(eff_sel))
						? DLY_OST[10:0] : 11'h000;
					clk_ready_q <= 1'b0;
				end
				ST_WAIT: begin
					// Clock waits run alongside the reset delay
					if (clk_cnt_q != 24'h000000)
						clk_cnt_q <= clk_cnt_q - 24'h000001;
					if (ost_cnt_q != 11'h000 && osc_tick)
						ost_cnt_q <= ost_cnt_q - 11'h001;
					if (clk_cnt_q == 24'h000000 && ost_cnt_q == 11'h000
						&& (!is_pll(osc_sel_q) || kind_q == K_OTHER || pll_locked))
						clk_ready_q <= 1'b1;
				end
				default: clk_ready_q <= clk_ready_q;
			endcase
		end
	end

	// Monitor delay counts from the release of the system clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_fail_monitor_cnt_q <= 16'h0000;
		end else if (pclken && !any_src) begin
			case (state_q)
				ST_HOLD: clock_fail_monitor_cnt_q <= is_xtal(eff_sel) | is_pll(eff_sel)
					? DLY_CLOCK_FAIL_MONITOR[15:0] : 16'h0000;
				ST_RUN: begin
					if (clock_fail_monitor_cnt_q != 16'h0000)
						clock_fail_monitor_cnt_q <= clock_fail_monitor_cnt_q - 16'h0001;
				end
				default: clock_fail_monitor_cnt_q <= clock_fail_monitor_cnt_q;
			endcase
		end
	end

	// Sequence: a source restarts it at once, whatever state it was in
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_HOLD;
			kind_q <= K_POR;
			rst_cnt_q <= 24'h000000;
			osc_sel_q <= 3'h0;
			master_reset <= 1'b1;
			sys_clock_release <= 1'b0;
			clock_source <= 3'h0;
			clock_fail_monitor_en <= 1'b0;
		end else if (pclken) begin
			if (any_src) begin
				state_q <= ST_HOLD;
				kind_q <= brownout_reset ? K_BOR : K_OTHER;
				master_reset <= 1'b1;
				sys_clock_release <= 1'b0;
				clock_fail_monitor_en <= 1'b0;
				rst_cnt_q <= 24'h000000;
			end else begin
				case (state_q)
					ST_HOLD: begin
						osc_sel_q <= eff_sel;
						clock_source <= eff_sel;
						rst_cnt_q <= rst_delay(kind_q);
						state_q <= ST_WAIT;
					end
					ST_WAIT: begin
						if (rst_cnt_q != 24'h000000)
							rst_cnt_q <= rst_cnt_q - 24'h000001;
						else
							master_reset <= 1'b0;
						// Registered ready keeps release a cycle behind both waits
						if (!master_reset && clk_ready_q) begin
							sys_clock_release <= 1'b1;
							state_q <= ST_RUN;
						end
					end
					ST_RUN: begin
						if (clock_fail_monitor_cnt_q == 16'h0000) begin
							clock_fail_monitor_en <= 1'b1;
							state_q <= ST_MON;
						end
					end
					ST_MON: state_q <= ST_MON;
					default: state_q <= ST_HOLD;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** hw/rcs_consts.vh ***
// Purpose: constants for the reset cause and release sequencer
// Assumes: APB byte addresses, 32-bit words, 10 MHz pclk
// Notes: times in their own units, cycle counts derived from them
`ifndef RCS_CONSTS_VH
`define RCS_CONSTS_VH

`define RCS_CLK_MHZ 10
// Register byte addresses
`define RCS_ADDR_STATUS 12'h000
`define RCS_ADDR_CLKSEL 12'h004
`define RCS_ADDR_SEQ 12'h008
// Status field positions
`define RCS_B_TRAP 15
`define RCS_B_ILL 14
`define RCS_B_CFGM 9
`define RCS_B_PROGMEM_SLEEP_POWER 8
`define RCS_B_PIN 7
`define RCS_B_SWR 6
`define RCS_B_SWDT 5
`define RCS_B_WATCHDOG_TIMEOUT_FLAG 4
`define RCS_B_SLEEP 3
`define RCS_B_IDLE 2
`define RCS_B_BOR 1
`define RCS_B_POR 0
`define RCS_STATUS_MASK 16'hC3FF
`define RCS_STATUS_POR 16'h0003
// Oscillator source codes
`define RCS_OSC_FRC 3'h0
`define RCS_OSC_FRCPLL 3'h1
`define RCS_OSC_XT 3'h2
`define RCS_OSC_XTPLL 3'h3
`define RCS_OSC_SOSC 3'h4
`define RCS_OSC_LOW_POWER_RC_OSCILLATOR 3'h5
`define RCS_OSC_FRCDIV 3'h7
`define RCS_OSC_EC 3'h6
// Timing: figures in microseconds, start-up count in oscillator periods, then cycles
`define RCS_TPOR_US 10
`define RCS_TPWRT_US 64000
`define RCS_TRST_US 10
`define RCS_TFSCM_US 100
`define RCS_TRC_US 10
`define RCS_TLOCK_US 200
`define RCS_OST_PERIODS 1024
`define RCS_CYC(us) ((us) * `RCS_CLK_MHZ)

`endif

// *** bench/rcs_seq_assertions.sv ***
// Purpose: port checks of the reset sequencer
// Assumes: bench timing TPOR 10, TPWRT 20, TRST 10 cycles
// Notes: delay bounds are sized to those cycle counts
`timescale 1ns/1ps
`default_nettype none
module rcs_seq_assertions (
	// Bus side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclken,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pslverr,
	// Sources and outputs
	input wire logic brownout_reset,
	input wire logic master_clear_pin,
	input wire logic watchdog_config_enable,
	input wire logic master_reset,
	input wire logic sys_clock_release,
	input wire logic clock_fail_monitor_en,
	input wire logic watchdog_enable,
	input wire logic progmem_sleep_power,
	input wire logic regulator_standby
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_src_sets_reset: assert property (pclken && master_clear_pin |-> ##[1:2] master_reset)
		else $error("pin source left master reset low");
	a_por_hold_reset: assert property ($rose(presetn) |-> master_reset [*8])
		else $error("master reset released early after power-on");
	a_bor_hold_reset: assert property ($fell(brownout_reset) |-> master_reset [*8])
		else $error("master reset released early after brown-out");
	a_pin_short_delay: assert property ($fell(master_clear_pin) |-> ##[1:20] !master_reset)
		else $error("pin reset delay too long");
	a_clk_after_rel: assert property ($rose(sys_clock_release) |-> !master_reset)
		else $error("clock released under master reset");
	a_mon_after_rel: assert property ($rose(clock_fail_monitor_en) |-> !$past(master_reset))
		else $error("clock monitor began before release");
	a_wdt_cfg_forced: assert property (watchdog_config_enable && $past(watchdog_config_enable)
		|-> watchdog_enable)
		else $error("watchdog off while configuration forces it");
	a_standby_inverse: assert property (regulator_standby != progmem_sleep_power)
		else $error("regulator standby does not follow program memory power");
	a_unmapped_err: assert property (psel && !penable && paddr == 12'h00C |=> pslverr)
		else $error("unmapped access not refused");
endmodule
bind rcs_reset_sequencer rcs_seq_assertions u_chk (.pclk, .presetn, .pclken, .psel, .penable,
	.paddr, .pslverr, .brownout_reset, .master_clear_pin, .watchdog_config_enable, .master_reset,
	.sys_clock_release, .clock_fail_monitor_en, .watchdog_enable, .progmem_sleep_power,
	.regulator_standby);
`default_nettype wire

// *** bench/rcs_cpu_model.sv ***
// Purpose: core that runs only with reset off and clock released
// Assumes: master_reset high holds the core
// Notes: stops at once on reset, as real core state would
`timescale 1ns/1ps
`default_nettype none
module rcs_cpu_model (
	// Controls
	input wire logic pclk,
	input wire logic master_reset,
	input wire logic sys_clock_release,
	// Status
	output logic running
);
	always @(posedge pclk or posedge master_reset) begin
		if (master_reset) begin
			running <= 1'b0;
		end else begin
			running <= sys_clock_release;
		end
	end
endmodule
`default_nettype wire

// *** bench/rcs_reset_sequencer_test.sv ***
// Purpose: register and sequence tests of the reset sequencer
// Assumes: short timing parameters, crystal as new oscillator
// Notes: each source is pulsed in turn, then status is read
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_sequencer_test;
	logic pclk, presetn, psel, penable, pwrite, osc_tick, err, running;
	logic clock_switch_en, watchdog_config_enable, master_reset, sys_clock_release;
	logic progmem_sleep_power, watchdog_enable, pready;
	logic pclken, two_speed_en, regulator_enable_pin, pll_locked, mon_en, reg_standby;
	logic [2:0] new_osc_config, current_osc_select, clock_source;
	logic [8:0] src;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int mismatches = 0;
	int n_compared = 0;
	int ticks, i;
	int bp[9] = '{7, 6, 4, 9, 15, 14, 1, 3, 2};
	rcs_reset_sequencer #(.TPOR_CYC(10), .TPWRT_CYC(20), .TRST_CYC(10), .TFSCM_CYC(30),
		.TRC_CYC(10), .TLOCK_CYC(20), .OST_PERIODS(8)) uut (.pclk(pclk), .presetn(presetn),
		.pclken(pclken), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(err),
		.brownout_reset(src[6]), .master_clear_pin(src[0]), .reset_instr(src[1]),
		.watchdog_timeout(src[2]), .config_mismatch(src[3]), .trap_conflict(src[4]),
		.illegal_access(src[5]), .pwrsave_sleep(src[7]), .pwrsave_idle(src[8]),
		.clock_switch_en(clock_switch_en), .two_speed_en(two_speed_en),
		.watchdog_config_enable(watchdog_config_enable),
		.regulator_enable_pin(regulator_enable_pin),
		.new_osc_config(new_osc_config), .current_osc_select(current_osc_select),
		.osc_tick(osc_tick), .pll_locked(pll_locked), .master_reset(master_reset),
		.sys_clock_release(sys_clock_release), .clock_source(clock_source),
		.clock_fail_monitor_en(mon_en), .watchdog_enable(watchdog_enable),
		.progmem_sleep_power(progmem_sleep_power), .regulator_standby(reg_standby));
	rcs_cpu_model cpu (.pclk(pclk), .master_reset(master_reset),
		.sys_clock_release(sys_clock_release), .running(running));
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		osc_tick <= ~osc_tick;
		ticks <= !presetn ? 0 : ticks + osc_tick;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		{psel, penable} <= 2'h0;
	endtask
	// Reset takes a few edges to show, so skip them before waiting
	task wait_run;
		repeat (3) @(posedge pclk);
		while (running !== 1'b1) @(posedge pclk);
	endtask
	task wrap_up;
		if (mismatches == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, src, osc_tick, ticks} = '0;
		{clock_switch_en, watchdog_config_enable} = 2'h2;
		{new_osc_config, current_osc_select} = {3'h2, 3'h6};
		{pclken, two_speed_en, regulator_enable_pin, pll_locked} = 4'h9;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h000, 0); chk("por status", 32'h00000003, rd);
		wait_run; chk("ost", 1, ticks >= 8);
		chk("por osc", 3'h2, clock_source);
		chk("monitor wait", 0, mon_en);
		repeat (35) @(posedge pclk);
		chk("monitor on", 1, mon_en);
		apb(1, 12'h000, 32'hFFFFFFFF); apb(0, 12'h000, 0);
		chk("all set", 32'h0000C3FF, rd);
		chk("no reset", 0, master_reset);
		chk("pm power", 1, progmem_sleep_power);
		chk("standby off", 0, reg_standby);
		chk("wdt sw", 1, watchdog_enable);
		apb(1, 12'h000, 0); apb(0, 12'h00C, 0); chk("unmapped", 1, err);
		chk("wdt off", 0, watchdog_enable);
		chk("pm off", 0, progmem_sleep_power);
		chk("standby on", 1, reg_standby);
		for (i = 0; i < 9; i++) begin
			src[i] <= 1'b1; @(posedge pclk); src[i] <= 1'b0; wait_run;
			apb(0, 12'h000, 0); chk("cause", 32'h1 << bp[i], rd);
			if (i == 0) chk("pin osc", 3'h6, clock_source);
			if (i == 6) chk("bor osc", 3'h2, clock_source);
			apb(1, 12'h000, 0);
		end
		src[2] <= 1'b1; @(posedge pclk); src[2] <= 1'b0; wait_run;
		src[7] <= 1'b1; @(posedge pclk); src[7] <= 1'b0;
		apb(0, 12'h000, 0); chk("watchdog_timeout_flag clear", 32'h00000008, rd);
		// A source seen while the enable is low must leave everything frozen
		pclken <= 1'b0; src[1] <= 1'b1; @(posedge pclk); src[1] <= 1'b0;
		repeat (2) @(posedge pclk); pclken <= 1'b1; @(posedge pclk);
		chk("frozen", 0, master_reset);
		{clock_switch_en, watchdog_config_enable} <= 2'h1;
		src[0] <= 1'b1; @(posedge pclk); src[0] <= 1'b0; wait_run;
		chk("fixed osc", 3'h2, clock_source);
		chk("wdt forced", 1, watchdog_enable);
		{new_osc_config, pll_locked} <= {3'h3, 1'b0};
		presetn <= 1'b0; @(posedge pclk); presetn <= 1'b1;
		apb(0, 12'h000, 0); chk("por again", 32'h00000003, rd);
		repeat (100) @(posedge pclk);
		chk("pll wait", 0, sys_clock_release);
		pll_locked <= 1'b1; wait_run;
		chk("pll osc", 3'h3, clock_source);
		two_speed_en <= 1'b1;
		presetn <= 1'b0; @(posedge pclk); presetn <= 1'b1;
		wait_run; chk("two speed", 3'h0, clock_source);
		wrap_up;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		wrap_up;
	end
endmodule
`default_nettype wire
